// >>> src/mas_regs.sv
// meter, alert, converter control, status and nvm default registers behind a two-wire slave
`timescale 1ns/100ps
`default_nettype none
`include "mas_defines.svh"
// What this block does
// - six-byte energy accumulator, read/write, reset zero
// - tick counter counts each accumulated conversion
// - alert flag sticky; host zero clears, one sets
// - force-low bit pulls alert pin low
// - reboot: off, reload defaults, delayed restart
// - clear bit holds accumulator and ticks zero
// - freeze bit stops accumulator and ticks
// - snapshot fault logs on fault rise
// - gate indicator reads zero when gate high
// - single-shot: each rewrite runs one conversion
// - first status byte shows seven switch flags and the on pin level
// - second status byte shows pin levels
// - nvm busy flag high during nvm writes
// - idle flag one when single-shot stopped
// - wrap flags on tick or accumulator overflow
// - nvm top bit restores fault log at boot
// - default-on bit: off or follow on pin
// - first nvm byte's low bits hold retry default 011
// - second nvm byte default 0x02 for control
// - charge select accumulates current, not power
module mas_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h10, // arbitrary default
  parameter int unsigned REBOOT_CYCLES =
    32'(64'(`MAS_REBOOT_DELAY_MS) * 64'd1000000 / 64'(`MAS_CLK_PERIOD_NS)),
  parameter int unsigned NVM_CYCLES =
    32'(64'(`MAS_NVM_WRITE_MS) * 64'd1000000 / 64'(`MAS_CLK_PERIOD_NS))
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire mas_pkg::mas_pins_s pins_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_o,
  output logic alert_oe_o,
  input wire mas_pkg::mas_status_s status_i,
  input wire logic gate_above_thr_i,
  input wire logic alert_event_i,
  input wire logic conv_done_i,
  input wire logic charge_count_sel_i,
  input wire logic [23:0] power_i,
  input wire logic [23:0] current_i,
  input wire logic [7:0] fault_log_i,
  input wire logic [7:0] conv_alert_log_i,
  output logic conv_run_o,
  output logic switch_enable_o,
  output logic nvm_reload_o,
  output logic fault_restore_o,
  output logic [7:0] nvm_fault_snapshot_o,
  output logic [7:0] nvm_conv_alert_snapshot_o,
  output logic fault_mask_default_o,
  output logic [2:0] retry_default_o,
  output logic [7:0] control2_default_o
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  mas_pkg::mas_pins_s pin_meta; // first stage only
  mas_pkg::mas_pins_s pin_s; // usable copy
  logic scl_q; // delayed scl for edges
  logic sda_q; // delayed sda for edges
  // two flops per pin, then an edge reference stage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= '1;
      pin_s <= '1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      pin_meta <= pins_i;
      pin_s <= pin_meta;
      scl_q <= pin_s.scl;
      sda_q <= pin_s.sda;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = pin_s.scl & ~scl_q;
  assign scl_fall = ~pin_s.scl & scl_q;
  assign bus_start = pin_s.scl & scl_q & sda_q & ~pin_s.sda;
  assign bus_stop = pin_s.scl & scl_q & ~sda_q & pin_s.sda;
  // ************************************************************
  // two-wire slave
  // ************************************************************
  mas_pkg::mas_i2c_e st; // slave state
  logic [3:0] bit_cnt; // bit within byte, 8 is ack slot
  logic [7:0] rx; // incoming shift
  logic [7:0] tx; // outgoing shift
  logic [7:0] ptr; // register pointer
  logic rd_dir; // read transfer
  logic host_ack; // host acked last read byte
  logic wr_stb; // one-cycle register write
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data; // byte at pointer
  // bus sequencing: sample on rise, change sda on fall
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= mas_pkg::MAS_IDLE;
      bit_cnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rd_dir <= 1'b0;
      host_ack <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        st <= mas_pkg::MAS_ADDR;
        bit_cnt <= 4'hf; // wait out the start's own clock fall
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        st <= mas_pkg::MAS_IDLE;
        sda_oe_o <= 1'b0;
      end else if (st != mas_pkg::MAS_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt < 4'h8) begin
            rx <= {rx[6:0], pin_s.sda};
          end else begin
            host_ack <= ~pin_s.sda;
          end
        end else if (scl_fall) begin
          if (bit_cnt == 4'hf) begin
            // fall closing the start is not a bit
            bit_cnt <= 4'h0;
          end else if (bit_cnt < 4'h7) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (st == mas_pkg::MAS_RDAT) begin
              tx <= {tx[6:0], 1'b0};
              sda_oe_o <= ~tx[6];
            end
          end else if (bit_cnt == 4'h7) begin
            // ack slot: slave acks its own address and every written byte
            bit_cnt <= 4'h8;
            case (st)
              mas_pkg::MAS_ADDR: begin
                if (rx[7:1] == DEV_ADDR) begin
                  sda_oe_o <= 1'b1;
                  rd_dir <= rx[0];
                end else begin
                  st <= mas_pkg::MAS_IDLE;
                  sda_oe_o <= 1'b0;
                end
              end
              mas_pkg::MAS_PTR: begin
                sda_oe_o <= 1'b1;
                ptr <= rx;
              end
              mas_pkg::MAS_WDAT: begin
                sda_oe_o <= 1'b1;
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_data <= rx;
                ptr <= ptr + 8'h01;
              end
              default: begin
                sda_oe_o <= 1'b0;
              end
            endcase
          end else begin
            // after ack slot: pick next byte phase
            bit_cnt <= 4'h0;
            sda_oe_o <= 1'b0;
            case (st)
              mas_pkg::MAS_ADDR: begin
                if (rd_dir) begin
                  st <= mas_pkg::MAS_RDAT;
                  tx <= rd_data;
                  sda_oe_o <= ~rd_data[7];
                  ptr <= ptr + 8'h01;
                end else begin
                  st <= mas_pkg::MAS_PTR;
                end
              end
              mas_pkg::MAS_PTR: begin
                st <= mas_pkg::MAS_WDAT;
              end
              mas_pkg::MAS_RDAT: begin
                if (host_ack) begin
                  tx <= rd_data;
                  sda_oe_o <= ~rd_data[7];
                  ptr <= ptr + 8'h01;
                end else begin
                  st <= mas_pkg::MAS_IDLE;
                end
              end
              default: begin
                st <= st;
              end
            endcase
          end
        end
      end
    end
  end
  assign sda_o = 1'b0;
  // ************************************************************
  // control registers
  // ************************************************************
  logic alert_raised, force_low, acc_clear, acc_freeze, snap_en, single_shot, shot_pend;
  logic reboot_req; // one-cycle reboot command
  logic ctrl_wr; // write of converter control
  assign ctrl_wr = wr_stb && (wr_addr == `MAS_CONV_CTRL);
  // alert control: event set wins over a host clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alert_raised <= 1'b0;
      force_low <= 1'b0;
    end else begin
      if (wr_stb && (wr_addr == `MAS_ALERT_CTRL)) begin
        alert_raised <= wr_data[`MAS_B_ALERT_RAISED] | alert_event_i;
        force_low <= wr_data[`MAS_B_FORCE_LOW];
      end else if (alert_event_i) begin
        alert_raised <= 1'b1;
      end
    end
  end
  // alert pin: open drain, low on alert or forced
  assign alert_o = 1'b0;
  assign alert_oe_o = force_low | alert_raised;
  // converter and meter control
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_clear <= 1'b0;
      acc_freeze <= 1'b0;
      snap_en <= 1'b0;
      single_shot <= 1'b0;
      shot_pend <= 1'b0;
      reboot_req <= 1'b0;
    end else begin
      reboot_req <= ctrl_wr & wr_data[`MAS_B_REBOOT];
      if (ctrl_wr) begin
        acc_clear <= wr_data[`MAS_B_CLEAR];
        acc_freeze <= wr_data[`MAS_B_FREEZE];
        snap_en <= wr_data[`MAS_B_SNAP_EN];
        single_shot <= wr_data[`MAS_B_SINGLE_SHOT];
        // a rewrite with the bit already set arms one conversion
        shot_pend <= wr_data[`MAS_B_SINGLE_SHOT] & single_shot;
      end else if (conv_done_i) begin
        shot_pend <= 1'b0;
      end
    end
  end
  assign conv_run_o = ~single_shot | shot_pend;
  // ************************************************************
  // energy accumulator and tick counter
  // ************************************************************
  logic [47:0] energy; // energy_accumulator
  logic [31:0] ticks; // conversion_tick_count
  logic tick_wrapped, acc_wrapped;
  logic acc_en; // sample accumulated this cycle
  logic [48:0] acc_sum;
  logic [2:0] e_idx;
  logic [1:0] t_idx;
  assign acc_en = conv_done_i & ~acc_clear & ~acc_freeze;
  // charge select swaps in current for power
  assign acc_sum = {1'b0, energy} + {25'h0, (charge_count_sel_i ? current_i : power_i)};
  assign e_idx = 3'(wr_addr - `MAS_ENERGY_LO);
  assign t_idx = 2'(wr_addr - `MAS_TICK_LO);
  // accumulator: clear holds zero, host byte write beats a sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      energy <= 48'h0;
    end else if (acc_clear) begin
      energy <= 48'h0;
    end else if (wr_stb && wr_addr >= `MAS_ENERGY_LO && wr_addr <= `MAS_ENERGY_HI) begin
      energy[8 * (3'd5 - e_idx) +: 8] <= wr_data;
    end else if (acc_en) begin
      energy <= acc_sum[47:0];
    end
  end
  // tick counter follows the accumulator's enables
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ticks <= 32'h0;
    end else if (acc_clear) begin
      ticks <= 32'h0;
    end else if (wr_stb && wr_addr >= `MAS_TICK_LO && wr_addr <= `MAS_TICK_HI) begin
      ticks[8 * (2'd3 - t_idx) +: 8] <= wr_data;
    end else if (acc_en) begin
      ticks <= ticks + 32'h1;
    end
  end
  // wrap flags stay until the clear bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_wrapped <= 1'b0;
      acc_wrapped <= 1'b0;
    end else if (acc_clear) begin
      tick_wrapped <= 1'b0;
      acc_wrapped <= 1'b0;
    end else begin
      if (acc_en && ticks == 32'hffffffff) begin
        tick_wrapped <= 1'b1;
      end
      if (acc_en && acc_sum[48]) begin
        acc_wrapped <= 1'b1;
      end
    end
  end
  // ************************************************************
  // nvm defaults, snapshot, boot and reboot
  // ************************************************************
  logic [15:0] nvm_ctrl; // nvm_default_control
  logic [31:0] nvm_cnt; // remaining nvm write cycles
  logic nvm_busy;
  logic [7:0] fault_q; // previous fault log
  logic snap_take;
  logic booted; // first cycle after reset seen
  logic [31:0] reboot_cnt; // remaining off time
  logic nvm_wr;
  assign nvm_busy = nvm_cnt != 32'h0;
  assign nvm_wr = wr_stb && !nvm_busy &&
    (wr_addr == `MAS_NVM_CTRL_1 || wr_addr == `MAS_NVM_CTRL_2);
  assign snap_take = snap_en && ((fault_log_i & ~fault_q) != 8'h00);
  // nvm words and write timer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nvm_ctrl <= `MAS_NVM_CTRL_RESET;
      nvm_cnt <= 32'h0;
      fault_q <= 8'h00;
      nvm_fault_snapshot_o <= 8'h00;
      nvm_conv_alert_snapshot_o <= 8'h00;
    end else begin
      fault_q <= fault_log_i;
      if (nvm_wr) begin
        if (wr_addr == `MAS_NVM_CTRL_1) begin
          nvm_ctrl[15:8] <= wr_data;
        end else begin
          nvm_ctrl[7:0] <= wr_data;
        end
      end
      if (snap_take) begin
        nvm_fault_snapshot_o <= fault_log_i;
        nvm_conv_alert_snapshot_o <= conv_alert_log_i;
      end
      if (nvm_wr || snap_take) begin
        nvm_cnt <= NVM_CYCLES;
      end else if (nvm_busy) begin
        nvm_cnt <= nvm_cnt - 32'h1;
      end
    end
  end
  assign fault_mask_default_o = nvm_ctrl[`MAS_B_NVM_FAULT_RESTORE];
  assign retry_default_o = nvm_ctrl[10:8];
  assign control2_default_o = nvm_ctrl[7:0];
  // boot pulse, reboot off-time and reload
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      booted <= 1'b0;
      reboot_cnt <= 32'h0;
      nvm_reload_o <= 1'b0;
      fault_restore_o <= 1'b0;
    end else begin
      booted <= 1'b1;
      nvm_reload_o <= reboot_req;
      fault_restore_o <= (~booted | (reboot_cnt == 32'h1)) &
        nvm_ctrl[`MAS_B_NVM_FAULT_RESTORE];
      if (reboot_req) begin
        reboot_cnt <= REBOOT_CYCLES;
      end else if (reboot_cnt != 32'h0) begin
        reboot_cnt <= reboot_cnt - 32'h1;
      end
    end
  end
  assign switch_enable_o = (reboot_cnt == 32'h0) & booted &
    nvm_ctrl[`MAS_B_NVM_DEFAULT_ON] & pin_s.on_pin;
  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rd_data = 8'h00;
    if (ptr >= `MAS_ENERGY_LO && ptr <= `MAS_ENERGY_HI) begin
      rd_data = energy[8 * (3'd5 - 3'(ptr - `MAS_ENERGY_LO)) +: 8];
    end else if (ptr >= `MAS_TICK_LO && ptr <= `MAS_TICK_HI) begin
      rd_data = ticks[8 * (2'd3 - 2'(ptr - `MAS_TICK_LO)) +: 8];
    end else if (ptr == `MAS_ALERT_CTRL) begin
      rd_data = {alert_raised, force_low, 6'h00};
    end else if (ptr == `MAS_CONV_CTRL) begin
      rd_data = {1'b0, acc_clear, acc_freeze, 2'h0, snap_en, ~gate_above_thr_i,
        single_shot};
    end else if (ptr == `MAS_STATUS_1) begin
      rd_data = {status_i.switch_on_cmd, status_i.degraded_switch_cooldown,
        status_i.switch_short_detected, pin_s.on_pin, status_i.output_good,
        status_i.overcurrent_cooldown, status_i.input_low_flag,
        status_i.input_high_flag};
    end else if (ptr == `MAS_STATUS_2) begin
      rd_data = {pin_s.io3, pin_s.io2, pin_s.io1, pin_s.alert_pin, nvm_busy,
        single_shot & ~shot_pend, tick_wrapped, acc_wrapped};
    end else if (ptr == `MAS_NVM_CTRL_1) begin
      rd_data = nvm_ctrl[15:8];
    end else if (ptr == `MAS_NVM_CTRL_2) begin
      rd_data = nvm_ctrl[7:0];
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  property p_alert_set;
    @(posedge clk_i) disable iff (!rst_b_i) alert_event_i |=> alert_raised;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert flag not set");
  property p_force_low;
    @(posedge clk_i) disable iff (!rst_b_i) force_low |-> alert_oe_o && !alert_o;
  endproperty
  a_force_low: assert property (p_force_low) else $error("alert pin not low");
  property p_clear_hold;
    @(posedge clk_i) disable iff (!rst_b_i) acc_clear [*2] |-> energy == 48'h0 && ticks == 32'h0;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("clear did not hold zero");
  property p_freeze;
    @(posedge clk_i) disable iff (!rst_b_i) acc_freeze && !acc_clear && !wr_stb |=> $stable(ticks);
  endproperty
  a_freeze: assert property (p_freeze) else $error("tick moved while frozen");
  property p_tick_inc;
    @(posedge clk_i) disable iff (!rst_b_i)
      acc_en && !wr_stb |=> ticks == $past(ticks) + 32'h1;
  endproperty
  a_tick_inc: assert property (p_tick_inc) else $error("tick did not count");
  property p_energy_add;
    @(posedge clk_i) disable iff (!rst_b_i)
      acc_en && !wr_stb |=> energy == $past(acc_sum[47:0]);
  endproperty
  a_energy_add: assert property (p_energy_add) else $error("sample not accumulated");
  property p_shot;
    @(posedge clk_i) disable iff (!rst_b_i)
      single_shot && shot_pend && conv_done_i && !ctrl_wr |=> !conv_run_o;
  endproperty
  a_shot: assert property (p_shot) else $error("single shot did not stop");
  property p_nvm_busy;
    @(posedge clk_i) disable iff (!rst_b_i) snap_take |=> nvm_busy [*8];
  endproperty
  a_nvm_busy: assert property (p_nvm_busy) else $error("nvm busy dropped early");
  property p_reboot_off;
    @(posedge clk_i) disable iff (!rst_b_i) reboot_req |-> ##1 nvm_reload_o ##0 !switch_enable_o;
  endproperty
  a_reboot_off: assert property (p_reboot_off) else $error("reboot did not switch off");
endmodule
`default_nettype wire

// >>> include/mas_defines.svh
// register offsets, field positions, reset values and timing for the meter/alert register group
`ifndef MAS_DEFINES_SVH
`define MAS_DEFINES_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define MAS_ENERGY_LO 8'h12
`define MAS_ENERGY_HI 8'h17
`define MAS_TICK_LO 8'h18
`define MAS_TICK_HI 8'h1b
`define MAS_ALERT_CTRL 8'h1c
`define MAS_CONV_CTRL 8'h1d
`define MAS_STATUS_1 8'h1e
`define MAS_STATUS_2 8'h1f
`define MAS_NVM_CTRL_1 8'h20
`define MAS_NVM_CTRL_2 8'h21
// ************************************************************
// field positions
// ************************************************************
`define MAS_B_ALERT_RAISED 7
`define MAS_B_FORCE_LOW 6
`define MAS_B_REBOOT 7
`define MAS_B_CLEAR 6
`define MAS_B_FREEZE 5
`define MAS_B_SNAP_EN 2
`define MAS_B_GATE_HIGH 1
`define MAS_B_SINGLE_SHOT 0
`define MAS_B_NVM_FAULT_RESTORE 15
`define MAS_B_NVM_DEFAULT_ON 11
// ************************************************************
// reset values
// ************************************************************
`define MAS_NVM_CTRL_RESET 16'hbb02
// ************************************************************
// timing
// ************************************************************
`define MAS_CLK_PERIOD_NS 100
`define MAS_REBOOT_DELAY_MS 3200
`define MAS_NVM_WRITE_MS 5
`endif

// >>> include/mas_pkg.sv
// types shared by the meter/alert register group
package mas_pkg;
  // serial slave states, one-hot
  typedef enum logic [4:0] {
    MAS_IDLE = 5'h01,
    MAS_ADDR = 5'h02,
    MAS_PTR = 5'h04,
    MAS_WDAT = 5'h08,
    MAS_RDAT = 5'h10
  } mas_i2c_e;
  // status flags produced by same-clock logic
  typedef struct packed {
    logic switch_on_cmd;
    logic degraded_switch_cooldown;
    logic switch_short_detected;
    logic output_good;
    logic overcurrent_cooldown;
    logic input_low_flag;
    logic input_high_flag;
  } mas_status_s;
  // pins sampled from outside the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic on_pin;
    logic io3;
    logic io2;
    logic io1;
    logic alert_pin;
  } mas_pins_s;
endpackage

// >>> sim/mas_host.sv
// two-wire host model that reads and writes the register group
`timescale 1ns/100ps
`default_nettype none
module mas_host (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  // ************************************************************
  // wire levels
  // ************************************************************
  logic pull = 1'b0; // host pulls data low
  initial scl_o = 1'b1;
  // pull-up wins unless some party pulls low
  assign sda_o = ~(pull | sda_oe_i);
  // ************************************************************
  // bus steps
  // ************************************************************
  // wait n edges, then step just past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one step: data and clock levels after n edges, five edges per phase
  task automatic st(input int n, input logic p, input logic c);
    wt(n);
    pull = p;
    scl_o = c;
  endtask
  // data falls while clock high, also works as a repeated start
  task automatic start;
    st(2, 1'b0, scl_o);
    st(3, 1'b0, 1'b1);
    st(5, 1'b1, 1'b1);
    st(5, 1'b1, 1'b0);
  endtask
  // data rises while clock high, then the bus rests
  task automatic stop;
    st(2, 1'b1, 1'b0);
    st(3, 1'b1, 1'b1);
    st(5, 1'b0, 1'b1);
    wt(5);
  endtask
  // data set in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    st(2, ~b, 1'b0);
    st(3, ~b, 1'b1);
    wt(4);
    s = sda_o;
    st(1, ~b, 1'b0);
  endtask
  // eight bits then the ninth; ack is the ninth bit seen low
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, s);
    ack = ~s;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_meter_alert_status_regs.sv
// self-checking bench for the meter, alert and status register group
`timescale 1ns/100ps
`default_nettype none
module tb_meter_alert_status_regs;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic scl, sda, on_pin, alert_event, conv_done, charge;
  logic gate_hi;
  logic [2:0] io; // io3, io2, io1 levels
  mas_pkg::mas_status_s status;
  logic [23:0] power, current;
  logic [7:0] flog, clog;
  logic sda_oe, alert_oe, conv_run, sw_en, reload, restore, fmask;
  logic sda_drv, alert_drv; // open-drain data levels, always low
  logic [2:0] retry;
  logic [7:0] snap_f, snap_c, ctl2;
  logic [7:0] av [4] = '{8'h00, 8'h80, 8'h40, 8'h00}; // alert control values
  mas_pkg::mas_pins_s pins;
  int num_errors = 0, checks_done = 0, restores = 0, reloads = 0;
  // alert pin has a pull-up, so it reads high unless pulled
  assign pins = {scl, sda, on_pin, io, ~alert_oe};
  mas_regs #(.REBOOT_CYCLES(200), .NVM_CYCLES(600)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins), .sda_o(sda_drv), .sda_oe_o(sda_oe),
    .alert_o(alert_drv), .alert_oe_o(alert_oe), .status_i(status), .gate_above_thr_i(gate_hi),
    .alert_event_i(alert_event), .conv_done_i(conv_done), .charge_count_sel_i(charge),
    .power_i(power), .current_i(current), .fault_log_i(flog), .conv_alert_log_i(clog),
    .conv_run_o(conv_run), .switch_enable_o(sw_en), .nvm_reload_o(reload),
    .fault_restore_o(restore), .nvm_fault_snapshot_o(snap_f),
    .nvm_conv_alert_snapshot_o(snap_c), .fault_mask_default_o(fmask),
    .retry_default_o(retry), .control2_default_o(ctl2));
  mas_host host_u (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  initial forever #50 clk_i = ~clk_i;
  // counts one-cycle reload and restore pulses
  always @(posedge clk_i) begin
    if (restore === 1'b1) restores <= restores + 1;
    if (reload === 1'b1) reloads <= reloads + 1;
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write n bytes from ptr on, most significant first
  task automatic wr(input logic [7:0] ptr, input int n, input logic [47:0] d);
    logic [7:0] q;
    logic a;
    host_u.start();
    host_u.xfer(8'h20, 1'b1, q, a);
    chk("address ack", 48'h1, {47'h0, a});
    host_u.xfer(ptr, 1'b1, q, a);
    for (int i = n - 1; i >= 0; i--) host_u.xfer(d[8*i+:8], 1'b1, q, a);
    host_u.stop();
  endtask
  // read n bytes from ptr on and compare
  task automatic rc(input string what, input logic [7:0] ptr, input int n, input logic [47:0] e);
    logic [7:0] q;
    logic a;
    logic [47:0] d;
    d = '0;
    host_u.start();
    host_u.xfer(8'h20, 1'b1, q, a);
    host_u.xfer(ptr, 1'b1, q, a);
    host_u.start();
    host_u.xfer(8'h21, 1'b1, q, a);
    for (int i = n - 1; i >= 0; i--) begin
      host_u.xfer(8'hff, i == 0, q, a);
      d[8*i+:8] = q;
    end
    host_u.stop();
    chk(what, e, d);
  endtask
  task automatic meter(input logic [47:0] e, input logic [47:0] t);
    rc("energy", 8'h12, 6, e);
    rc("ticks", 8'h18, 4, t);
  endtask
  // one-cycle pulse on a strobe input
  task automatic pulse(ref logic s);
    host_u.wt(1);
    s = 1'b1;
    host_u.wt(1);
    s = 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog, about twice the expected run
  initial begin
    #6000000;
    num_errors++;
    close_out();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {on_pin, alert_event, conv_done, charge, gate_hi} = 5'h10;
    io = 3'h5;
    status = '0;
    power = 24'h000010;
    current = 24'h000000;
    flog = 8'h00;
    clog = 8'h00;
    host_u.wt(12);
    rst_b_i = 1'b1;
    host_u.wt(3);
    meter(48'h0, 48'h0);
    rc("nvm word", 8'h20, 2, 48'hbb02);
    chk("nvm defaults", 48'hb02, {36'h0, fmask, retry, ctl2});
    chk("boot restore", 48'h1, 48'(restores));
    wr(8'h12, 6, 48'h0123456789ab);
    rc("energy", 8'h12, 6, 48'h0123456789ab);
    wr(8'h1c, 1, 48'h3f);
    rc("alert ctl", 8'h1c, 1, 48'h0);
    wr(8'h1d, 1, 48'h18);
    rc("conv ctl", 8'h1d, 1, 48'h02);
    gate_hi = 1'b1;
    rc("conv ctl", 8'h1d, 1, 48'h00);
    gate_hi = 1'b0;
    rc("unmapped", 8'h40, 1, 48'h0);
    chk("pin drive", 48'h0, {46'h0, sda_drv, alert_drv});
    $display("test access done");
    wr(8'h1d, 1, 48'h40);
    pulse(conv_done);
    meter(48'h0, 48'h0);
    wr(8'h1d, 1, 48'h00);
    repeat (3) pulse(conv_done);
    meter(48'h30, 48'h3);
    wr(8'h1d, 1, 48'h20);
    pulse(conv_done);
    meter(48'h30, 48'h3);
    wr(8'h1d, 1, 48'h00);
    current = 24'h000005;
    charge = 1'b1;
    pulse(conv_done);
    charge = 1'b0;
    meter(48'h35, 48'h4);
    wr(8'h12, 6, 48'hffffffffffff);
    wr(8'h18, 4, 48'hffffffff);
    power = 24'h000020;
    pulse(conv_done);
    meter(48'h1f, 48'h0);
    rc("status2", 8'h1f, 1, 48'hb3);
    wr(8'h1d, 1, 48'h40);
    wr(8'h1d, 1, 48'h00);
    rc("status2", 8'h1f, 1, 48'hb0);
    $display("test meter done");
    pulse(alert_event);
    rc("alert ctl", 8'h1c, 1, 48'h80);
    for (int i = 0; i < 4; i++) begin
      wr(8'h1c, 1, {40'h0, av[i]});
      rc("alert ctl", 8'h1c, 1, {40'h0, av[i]});
      chk("alert pin", {47'h0, |av[i]}, {47'h0, alert_oe});
      rc("status2", 8'h1f, 1, {40'h0, 3'h5, ~|av[i], 4'h0});
    end
    status = 7'h55;
    rc("status1", 8'h1e, 1, 48'hb5);
    on_pin = 1'b0;
    rc("status1", 8'h1e, 1, 48'ha5);
    on_pin = 1'b1;
    io = 3'h2;
    rc("status2", 8'h1f, 1, 48'h50);
    io = 3'h5;
    $display("test alert and status done");
    wr(8'h1d, 1, 48'h01);
    chk("run", 48'h0, 48'(conv_run));
    rc("status2", 8'h1f, 1, 48'hb4);
    wr(8'h1d, 1, 48'h01);
    chk("run", 48'h1, 48'(conv_run));
    pulse(conv_done);
    chk("run", 48'h0, 48'(conv_run));
    wr(8'h1d, 1, 48'h00);
    chk("run", 48'h1, 48'(conv_run));
    rc("status2", 8'h1f, 1, 48'hb0);
    $display("test single shot done");
    wr(8'h1d, 1, 48'h04);
    clog = 8'h5a;
    flog = 8'h21;
    rc("status2", 8'h1f, 1, 48'hb8);
    chk("snapshots", 48'h215a, {32'h0, snap_f, snap_c});
    host_u.wt(600);
    rc("status2", 8'h1f, 1, 48'hb0);
    $display("test snapshot done");
    chk("switch", 48'h1, 48'(sw_en));
    for (int i = 0; i < 2; i++) begin
      wr(8'h20, 1, i ? 48'hbb : 48'hb3);
      host_u.wt(650);
      wr(8'h1d, 1, 48'h80);
      chk("switch off", 48'h0, 48'(sw_en));
      host_u.wt(250);
      chk("switch after boot", 48'(i), 48'(sw_en));
    end
    chk("reloads", 48'h2, 48'(reloads));
    chk("restores", 48'h3, 48'(restores));
    $display("test reboot done");
    close_out();
  end
endmodule
`default_nettype wire
